// file: logic/crcm_engine.sv
// Multi-byte CRC-32 engine: up to eight bytes per clock, result one clock later.
// Assumes feeding logic on the same clock; byte lane 0 is bits [7:0], sent first.
`timescale 1ns/1ps
`default_nettype none
module crcm_engine (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic checksumClear,
  input wire logic inputValidStrobe,
  output logic inputReady,
  input wire logic [crcm_pkg::CNT_W-1:0] validByteCount,
  input wire logic [crcm_pkg::DATA_W-1:0] inputWord,
  output logic [crcm_pkg::CRC_W-1:0] checksumResult,
  output logic resultValid
);
  import crcm_pkg::*;

  // Count value 0..7 means 1..8 bytes valid, lanes from bit 0 upward
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[31] ^ b[7-i]) r = {r[30:0], 1'b0} ^ CRC_POLY;
      else r = {r[30:0], 1'b0};
    end
    return r;
  endfunction : crc_byte

  function automatic logic [31:0] finish(input logic [31:0] c);
    logic [31:0] r;
    r = ~c;
    return {r[7:0], r[15:8], r[23:16], r[31:24]};
  endfunction : finish

  // Folds lanes 0..n in ascending order into the running CRC
  function automatic logic [31:0] fold_word(input logic [31:0] c, input logic [63:0] w,
      input logic [2:0] n);
    logic [31:0] r;
    r = c;
    for (int k = 0; k < 8; k++) begin
      if (k <= int'(n)) begin
        r = crc_byte(r, w[8*k +: 8]);
      end
    end
    return r;
  endfunction : fold_word

  // The lane loop assumes eight-bit lanes filling the word, the byte reversal a 32-bit CRC
  initial begin
    if (DATA_W != 8 * BYTES_MAX) $error("word width must hold eight-bit lanes");
    if (CRC_W != 32) $error("result path serves a 32-bit CRC only");
    if (2 ** CNT_W != BYTES_MAX) $error("count field must span every lane");
  end

  crcm_beat_if beat ();

  crcm_skid_buf #(.DEPTH(BUF_DEPTH)) u_buf (
    .clk(clk),
    .sys_rst(sys_rst || checksumClear),
    .inValid(inputValidStrobe),
    .inReady(inputReady),
    .inWord(inputWord),
    .inCnt(validByteCount),
    .out(beat)
  );

  logic [31:0] crc_q, crc_d;
  logic [31:0] res_q, res_d;
  logic rv_q, rv_d;
  logic [31:0] acc;

  assign beat.ready = 1'b1;

  always_comb begin
    acc = fold_word(crc_q, beat.word, beat.cnt);
    crc_d = crc_q;
    res_d = res_q;
    rv_d = 1'b0;
    if (beat.valid) begin
      crc_d = acc;
      res_d = finish(acc);
      rv_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || checksumClear) begin
      crc_q <= CRC_SEED;
      res_q <= RESULT_RST;
      rv_q <= 1'b0;
    end else begin
      crc_q <= crc_d;
      res_q <= res_d;
      rv_q <= rv_d;
    end
  end

  assign checksumResult = res_q;
  assign resultValid = rv_q;

  property p_clear_seeds;
    @(posedge clk) checksumClear |=> (crc_q == CRC_SEED && !resultValid);
  endproperty
  a_clear_seeds: assert property (p_clear_seeds) else $error("clear did not reseed");


  property p_result_form;
    @(posedge clk) disable iff (sys_rst || checksumClear)
      beat.valid |=> (checksumResult == finish(crc_q));
  endproperty
  a_result_form: assert property (p_result_form) else $error("bad result form");


  property p_one_clock;
    @(posedge clk) disable iff (sys_rst || checksumClear)
      beat.valid |=> resultValid;
  endproperty
  a_one_clock: assert property (p_one_clock) else $error("result not one clock later");


  property p_hold;
    @(posedge clk) disable iff (sys_rst || checksumClear)
      !beat.valid |=> $stable(crc_q) && !resultValid;
  endproperty
  a_hold: assert property (p_hold) else $error("CRC moved without data");


  property p_count;
    @(posedge clk) disable iff (sys_rst || checksumClear)
      (beat.valid && beat.cnt == 3'h0) |=>
        crc_q == crc_byte($past(crc_q), $past(beat.word[7:0]));
  endproperty
  a_count: assert property (p_count) else $error("one-byte count wrong");


  property p_ready;
    @(posedge clk) disable iff (sys_rst) inputReady;
  endproperty
  a_ready: assert property (p_ready) else $error("buffer stalled");


  property p_enter;
    @(posedge clk) disable iff (sys_rst || checksumClear)
      inputValidStrobe |-> beat.valid;
  endproperty
  a_enter: assert property (p_enter) else $error("beat lost");


  property p_seed_first;
    @(posedge clk) sys_rst |=> crc_q == 32'hFFFFFFFF;
  endproperty
  a_seed_first: assert property (p_seed_first) else $error("seed wrong");

  property p_result_stands;
    @(posedge clk) disable iff (sys_rst || checksumClear)
      !beat.valid |=> $stable(checksumResult);
  endproperty
  a_result_stands: assert property (p_result_stands) else $error("result moved idle");

  property p_pulse_cause;
    @(posedge clk) disable iff (sys_rst || checksumClear)
      resultValid |-> $past(beat.valid);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without beat");

  property p_clear_result;
    @(posedge clk) checksumClear |=> (checksumResult == RESULT_RST && !resultValid);
  endproperty
  a_clear_result: assert property (p_clear_result) else $error("clear kept result");

  property p_full_fold;
    @(posedge clk) disable iff (sys_rst || checksumClear)
      (beat.valid && beat.cnt == 3'h7) |=>
        crc_q == fold_word($past(crc_q), $past(beat.word), 3'h7);
  endproperty
  a_full_fold: assert property (p_full_fold) else $error("eight-byte fold wrong");

  property p_no_stall;
    @(posedge clk) disable iff (sys_rst || checksumClear)
      inputValidStrobe |-> inputReady;
  endproperty
  a_no_stall: assert property (p_no_stall) else $error("strobed beat refused");

  c_back_to_back: cover property (@(posedge clk) beat.valid ##1 beat.valid);

  c_full: cover property (@(posedge clk) beat.valid && beat.cnt == 3'h7);
  c_partial: cover property (@(posedge clk) beat.valid && beat.cnt == 3'h3);
  c_clear_mid: cover property (@(posedge clk) beat.valid ##1 checksumClear);
endmodule : crcm_engine
`default_nettype wire

// file: logic/crcm_pkg.sv
// Constants and types for the multi-byte CRC-32 engine.
// Assumes one clock domain and a synchronous active-high reset.
package crcm_pkg;
  localparam int DATA_W = 64;
  localparam int CNT_W = 3;
  localparam int CRC_W = 32;
  localparam int BYTES_MAX = 8;
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_SEED = 32'hFFFFFFFF;
  localparam logic [31:0] RESULT_RST = 32'h00000000;
  localparam int BUF_DEPTH = 2;
  typedef logic [DATA_W-1:0] crcm_word_t;
  typedef logic [CNT_W-1:0] crcm_cnt_t;
endpackage : crcm_pkg

// file: logic/crcm_beat_if.sv
// Beat carrier between the input buffer and the CRC engine.
// Assumes both ends share the block clock.
`timescale 1ns/1ps
`default_nettype none
interface crcm_beat_if;
  logic valid;
  logic ready;
  crcm_pkg::crcm_word_t word;
  crcm_pkg::crcm_cnt_t cnt;
  modport src (output valid, output word, output cnt, input ready);
  modport snk (input valid, input word, input cnt, output ready);
endinterface : crcm_beat_if
`default_nettype wire

// file: logic/crcm_skid_buf.sv
// Two-entry buffer for data beats with valid/ready on both sides.
// Assumes the sink side is the CRC engine on the same clock.
`timescale 1ns/1ps
`default_nettype none
module crcm_skid_buf #(
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [crcm_pkg::DATA_W-1:0] inWord,
  input wire logic [crcm_pkg::CNT_W-1:0] inCnt,
  crcm_beat_if.src out
);
  import crcm_pkg::*;
  localparam int ENT_W = DATA_W + CNT_W;
  initial begin
    if (DEPTH != 2) $error("crcm_skid_buf serves only two entries");
  end
  logic [ENT_W-1:0] mem_q [2];
  logic [ENT_W-1:0] mem_d [2];
  logic wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;
  logic bypass;
  // An empty buffer hands the beat straight through in the same clock, adding no latency
  assign bypass = (cnt_q == 2'h0);
  assign inReady = (cnt_q != 2'h2);
  assign out.valid = bypass ? inValid : 1'b1;
  assign out.word = bypass ? inWord : mem_q[rdPtr_q][ENT_W-1:CNT_W];
  assign out.cnt = bypass ? inCnt : mem_q[rdPtr_q][CNT_W-1:0];
  assign push = inValid && inReady && !(bypass && out.ready);
  assign pop = out.valid && out.ready && !bypass;
  always_comb begin
    mem_d = mem_q;
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wrPtr_q] = {inWord, inCnt};
      wrPtr_d = ~wrPtr_q;
    end
    if (pop) begin
      rdPtr_d = ~rdPtr_q;
    end
    cnt_d = cnt_q + 2'(push) - 2'(pop);
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      cnt_q <= cnt_d;
    end
    mem_q <= mem_d;
  end
endmodule : crcm_skid_buf
`default_nettype wire

// file: dv/crcm_feeder.sv
// Feeder model: user logic offering beats to the engine.
// Assumes the bench hands it one beat request per clock.
`timescale 1ns/1ps
`default_nettype none
module crcm_feeder (
  input wire logic clk,
  input wire logic req,
  input wire logic [63:0] reqWord,
  input wire logic [2:0] reqCnt,
  output logic strobe,
  output logic [63:0] word,
  output logic [2:0] cnt
);
  logic reqS;
  logic [63:0] wordS;
  logic [2:0] cntS;
  initial {strobe, word, cnt} = '0;
  // Requests are taken at the edge and shown a small delay later
  // Idle cycles invert the lines so that stale data never looks valid
  always @(posedge clk) begin
    reqS = req;
    wordS = reqWord;
    cntS = reqCnt;
    #1;
    strobe = reqS;
    word = reqS ? wordS : ~word;
    cnt = reqS ? cntS : ~cnt;
  end
endmodule : crcm_feeder
`default_nettype wire

// file: dv/tb_crcm_engine.sv
// Self-checking bench for the CRC engine, with a reference fold.
// Assumes the feeder model and the design package.
`timescale 1ns/1ps
`default_nettype none
module tb_crcm_engine;
  import crcm_pkg::*;
  logic clk = 0, rst = 1, clr = 0, req = 0, stb, rdy, rv;
  logic [63:0] rw = '0, w;
  logic [2:0] rc = '0, c;
  logic [31:0] res, crc = CRC_SEED, s = 32'h5835, q[$];
  int bad_count = 0, check_count = 0;
  always #20 clk = ~clk;
  crcm_feeder i_crcm_feeder (.clk(clk), .req(req), .reqWord(rw), .reqCnt(rc),
    .strobe(stb), .word(w), .cnt(c));
  crcm_engine i_crcm_engine (.clk(clk), .sys_rst(rst), .checksumClear(clr),
    .inputValidStrobe(stb), .inputReady(rdy), .validByteCount(c), .inputWord(w),
    .checksumResult(res), .resultValid(rv));
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // Lane 0 first, MSB first within each byte, no reflection
  task automatic beat(logic [2:0] n);
    logic [63:0] d;
    d = {rnd(), rnd()};
    for (int b = 0; b <= n; b++)
      for (int k = 7; k >= 0; k--)
        crc = {crc[30:0], 1'b0} ^ ((crc[31] ^ d[8*b+k]) ? CRC_POLY : 32'h0);
    q.push_back({~crc[7:0], ~crc[15:8], ~crc[23:16], ~crc[31:24]});
    req = 1;
    rw = d;
    rc = n;
    @(posedge clk);
    #1;
  endtask : beat
  task automatic idle(int n);
    req = 0;
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  always @(negedge clk) begin
    if (rv === 1'b1) check(res, q.pop_front());
    if (!rst) check({31'h0, rdy}, 32'h1);
  end
  initial begin
    repeat (8) @(posedge clk);
    #1 rst = 0;
    for (int i = 0; i < 32; i++) beat(i[2:0]);
    for (int i = 0; i < 200; i++) begin
      if (rnd() & 1) beat(s[6:4]);
      else idle(1);
    end
    idle(5);
    clr = 1;
    @(posedge clk);
    #1 clr = 0;
    crc = CRC_SEED;
    check(res, RESULT_RST);
    for (int i = 0; i < 8; i++) beat(3'h7 - i[2:0]);
    idle(6);
    check(32'(q.size()), 32'h0);
    conclude();
  end
  initial begin
    #400000;
    bad_count++;
    conclude();
  end
endmodule : tb_crcm_engine
`default_nettype wire
